// ==== pcc_pkg.sv ====
//------------------------------------------------------------------------
// Summary of operation
// - answer only slave address 0010010, ignore others
// - serial port runs at up to 400kb/s
// - frame is register address then data bytes
// - no bus transactions before power-on sequence done
// - droop monitoring only with low/high input limit
// - droop below threshold lowers input current limit
// - charger type 000 always enables droop guard
// - other types follow software droop enable bit
// - power path threshold: enter mode, cut charge
// - no charge termination in auto power path
// - supplement mode: no termination, exit below 0V
// - short in supplement: disable rail, wait, retry
// - above regulation temperature: reduce charge current
// - shutdown: open input switch, keep battery switch
//------------------------------------------------------------------------
package pcc_pkg;

    localparam logic [6:0] DEV_ADDR        = 7'h12;
    localparam int         REG_COUNT       = 16;
    localparam logic [7:0] CONTROL_REG_ZERO_ADDR   = 8'h00;
    localparam logic [7:0] CHARGER_STATUS_REG_ADDR = 8'h0a;
    localparam logic [7:0] CONTROL_REG_ZERO_RST    = 8'h91;
    // read-only bit of control_reg_zero (mode detect result)
    localparam logic [7:0] CONTROL_REG_ZERO_RO     = 8'h02;
    localparam int         DROOP_GUARD_ENABLE_BIT  = 3;
    localparam int         THERMAL_EVENT_BIT       = 2;

    // charger_status_reg field positions
    localparam int ST_PATH_BIT     = 0;
    localparam int ST_SUPPL_BIT    = 1;
    localparam int ST_SHORT_BIT    = 2;
    localparam int ST_THERM_BIT    = 3;
    localparam int ST_SHUT_BIT     = 4;
    localparam int ST_DROOP_BIT    = 5;

    localparam logic [2:0] CHARGER_TYPE_SDP = 3'h0;
    localparam logic [1:0] INPUT_LIMIT_LOW  = 2'h0;
    localparam logic [1:0] INPUT_LIMIT_HIGH = 2'h1;

    localparam int CLK_FREQ_HZ        = 125_000_000;
    localparam int US_CYCLES          = CLK_FREQ_HZ / 1_000_000;
    localparam int SHORT_RECOV_US_DEF = 64;

    typedef struct packed {
        logic [1:0] input_limit_sel;
        logic [2:0] charger_type_code;
        logic       vin_below_droop;
        logic       sys_at_power_path;
        logic       sys_below_bat;
        logic       bat_below_sys;
        logic       bat_sys_short;
        logic       die_above_reg;
        logic       die_above_shutdown;
        logic       die_cooled;
    } pcc_sense_type;

    typedef struct packed {
        logic input_droop_guard;
        logic reduce_input_limit;
        logic auto_power_path_mode;
        logic charge_cut;
        logic termination_enable;
        logic supplement;
        logic sys_output_enable;
        logic thermal_reduce;
        logic input_switch_on;
        logic battery_switch_on;
    } pcc_mode_type;

endpackage

// ==== pcc_regmem.sv ====
module pcc_regmem
    import pcc_pkg::*;
(
    input  wire logic       clock_i,   // system clock
    input  wire logic       we_i,      // write strobe
    input  wire logic [3:0] waddr_i,   // write address
    input  wire logic [7:0] wdata_i,   // write data
    input  wire logic [3:0] raddr_i,   // read address
    output logic      [7:0] rdata_o    // registered read data
);
    logic [7:0] mem [REG_COUNT];
    logic [7:0] rdata_r;

    // no reset: contents are undefined until software writes them
    always_ff @(posedge clock_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_r <= mem[raddr_i];
    end

    assign rdata_o = rdata_r;
endmodule // pcc_regmem

// ==== pcc_charger_ctrl.sv ====
module pcc_charger_ctrl
    import pcc_pkg::*;
#(
    parameter int SHORT_RECOV_US = SHORT_RECOV_US_DEF
) (
    input  wire logic          clock_i,          // 125 MHz system clock
    input  wire logic          rst_i,            // sync reset, high
    input  wire logic          power_on_done_i,  // power-on sequence ok
    input  wire logic          scl_i,            // serial clock in
    input  wire logic          sda_i,            // serial data in
    output logic               sda_o,            // serial data out
    output logic               sda_oe_o,         // drive sda low
    input  wire pcc_sense_type sense_i,          // comparator levels
    output pcc_mode_type       modes_o,          // mode decisions
    output logic [7:0]         status_o          // charger status byte
);
    //--------------------------------------------------------------------
    // serial slave
    //--------------------------------------------------------------------
    typedef enum {
        SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_REG, SL_REG_ACK,
        SL_WR, SL_WR_ACK, SL_RD, SL_RD_ACK
    } pcc_slave_type;

    pcc_slave_type st_r, st_nxt;
    logic       scl_q_r, sda_q_r;
    logic [7:0] sh_r, sh_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic       rw_r, rw_nxt;
    logic       oe_r, oe_nxt;
    logic [7:0] ctrl0_r, ctrl0_nxt;
    logic       mem_we;
    logic [7:0] mem_rdata;
    logic [7:0] rd_byte;
    logic [7:0] status_r, status_nxt;
    logic       scl_rise, scl_fall, bus_start, bus_stop;

    function automatic logic in_map(input logic [7:0] a);
        return a < 8'(REG_COUNT);
    endfunction

    assign scl_rise  = scl_i & ~scl_q_r;
    assign scl_fall  = ~scl_i & scl_q_r;
    assign bus_start = scl_i & scl_q_r & sda_q_r & ~sda_i;
    assign bus_stop  = scl_i & scl_q_r & ~sda_q_r & sda_i;

    always_comb begin
        if (ptr_r == CONTROL_REG_ZERO_ADDR) begin
            rd_byte = ctrl0_r;
        end else if (ptr_r == CHARGER_STATUS_REG_ADDR) begin
            rd_byte = status_r;
        end else if (in_map(ptr_r)) begin
            rd_byte = mem_rdata;
        end else begin
            rd_byte = 8'h00;
        end
    end

    always_comb begin
        st_nxt    = st_r;
        sh_nxt    = sh_r;
        cnt_nxt   = cnt_r;
        ptr_nxt   = ptr_r;
        rw_nxt    = rw_r;
        oe_nxt    = oe_r;
        ctrl0_nxt = ctrl0_r;
        mem_we    = 1'b0;
        case (st_r)
            SL_IDLE: ;
            SL_ADDR, SL_REG, SL_WR: begin
                if (scl_rise && cnt_r < 4'h8) begin
                    sh_nxt  = {sh_r[6:0], sda_i};
                    cnt_nxt = cnt_r + 4'h1;
                end else if (scl_fall && cnt_r == 4'h8) begin
                    cnt_nxt = 4'h0;
                    oe_nxt  = 1'b1;
                    if (st_r == SL_ADDR) begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                            rw_nxt = sh_r[0];
                            st_nxt = SL_ADDR_ACK;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = SL_IDLE;
                        end
                    end else if (st_r == SL_REG) begin
                        ptr_nxt = sh_r;
                        st_nxt  = SL_REG_ACK;
                    end else begin
                        if (ptr_r == CONTROL_REG_ZERO_ADDR) begin
                            ctrl0_nxt = (sh_r & ~CONTROL_REG_ZERO_RO)
                                      | (ctrl0_r & CONTROL_REG_ZERO_RO);
                        end else if (ptr_r != CHARGER_STATUS_REG_ADDR) begin
                            mem_we = in_map(ptr_r);
                        end
                        ptr_nxt = ptr_r + 8'h01;
                        st_nxt  = SL_WR_ACK;
                    end
                end
            end
            SL_ADDR_ACK, SL_REG_ACK, SL_WR_ACK: begin
                if (scl_fall) begin
                    oe_nxt = 1'b0;
                    if (st_r == SL_ADDR_ACK && rw_r) begin
                        sh_nxt = rd_byte;
                        oe_nxt = ~rd_byte[7];
                        st_nxt = SL_RD;
                    end else if (st_r == SL_ADDR_ACK) begin
                        st_nxt = SL_REG;
                    end else begin
                        st_nxt = SL_WR;
                    end
                end
            end
            SL_RD: begin
                if (scl_fall) begin
                    if (cnt_r == 4'h7) begin
                        cnt_nxt = 4'h0;
                        oe_nxt  = 1'b0;
                        st_nxt  = SL_RD_ACK;
                    end else begin
                        sh_nxt  = {sh_r[6:0], 1'b0};
                        oe_nxt  = ~sh_r[6];
                        cnt_nxt = cnt_r + 4'h1;
                    end
                end
            end
            SL_RD_ACK: begin
                // cnt_r marks a seen master ack
                if (scl_rise) begin
                    if (sda_i) begin
                        st_nxt = SL_IDLE;
                    end else begin
                        ptr_nxt = ptr_r + 8'h01;
                        cnt_nxt = 4'h1;
                    end
                end else if (scl_fall && cnt_r == 4'h1) begin
                    cnt_nxt = 4'h0;
                    sh_nxt  = rd_byte;
                    oe_nxt  = ~rd_byte[7];
                    st_nxt  = SL_RD;
                end
            end
            default: st_nxt = SL_IDLE;
        endcase
        if (bus_start) begin
            st_nxt  = SL_ADDR;
            cnt_nxt = 4'h0;
            oe_nxt  = 1'b0;
        end else if (bus_stop) begin
            st_nxt = SL_IDLE;
            oe_nxt = 1'b0;
        end
        if (!power_on_done_i) begin
            st_nxt = SL_IDLE;
            oe_nxt = 1'b0;
        end
        // set wins over a software clear in the same cycle
        if (sense_i.die_above_shutdown) begin
            ctrl0_nxt[THERMAL_EVENT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_r    <= SL_IDLE;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            sh_r    <= 8'h00;
            cnt_r   <= 4'h0;
            ptr_r   <= 8'h00;
            rw_r    <= 1'b0;
            oe_r    <= 1'b0;
            ctrl0_r <= CONTROL_REG_ZERO_RST;
        end else begin
            st_r    <= st_nxt;
            scl_q_r <= scl_i;
            sda_q_r <= sda_i;
            sh_r    <= sh_nxt;
            cnt_r   <= cnt_nxt;
            ptr_r   <= ptr_nxt;
            rw_r    <= rw_nxt;
            oe_r    <= oe_nxt;
            ctrl0_r <= ctrl0_nxt;
        end
    end

    pcc_regmem u_regmem (
        .clock_i (clock_i),
        .we_i    (mem_we),
        .waddr_i (ptr_r[3:0]),
        .wdata_i (sh_r),
        .raddr_i (ptr_r[3:0]),
        .rdata_o (mem_rdata)
    );

    //--------------------------------------------------------------------
    // charger mode decisions
    //--------------------------------------------------------------------
    typedef enum { SUP_IDLE, SUP_ACTIVE, SUP_SHORT } pcc_suppl_type;

    pcc_suppl_type sup_r, sup_nxt;
    pcc_mode_type  modes_r, modes_nxt;
    logic [6:0]    us_cnt_r, us_cnt_nxt;
    logic          us_tick;
    logic [15:0]   recov_r, recov_nxt;
    logic          droop_en;

    assign us_tick = (us_cnt_r == 7'(US_CYCLES - 1));

    always_comb begin
        us_cnt_nxt = us_tick ? 7'h00 : us_cnt_r + 7'h01;
        sup_nxt    = sup_r;
        recov_nxt  = recov_r;
        modes_nxt  = modes_r;
        droop_en = (sense_i.charger_type_code == CHARGER_TYPE_SDP)
                 | ctrl0_r[DROOP_GUARD_ENABLE_BIT];
        // only the two usb limits are watched
        modes_nxt.input_droop_guard = droop_en
            & (sense_i.input_limit_sel == INPUT_LIMIT_LOW
             | sense_i.input_limit_sel == INPUT_LIMIT_HIGH);
        modes_nxt.reduce_input_limit = modes_nxt.input_droop_guard
                                     & sense_i.vin_below_droop;
        modes_nxt.auto_power_path_mode = sense_i.sys_at_power_path;
        modes_nxt.charge_cut           = sense_i.sys_at_power_path;
        case (sup_r)
            SUP_IDLE: begin
                if (sense_i.sys_below_bat) begin
                    sup_nxt = SUP_ACTIVE;
                end
            end
            SUP_ACTIVE: begin
                // short: drop rail, start recovery wait
                if (sense_i.bat_sys_short) begin
                    sup_nxt   = SUP_SHORT;
                    recov_nxt = 16'(SHORT_RECOV_US);
                end else if (sense_i.bat_below_sys) begin
                    sup_nxt = SUP_IDLE;
                end
            end
            SUP_SHORT: begin
                if (us_tick) begin
                    if (recov_r <= 16'h0001) begin
                        sup_nxt = SUP_ACTIVE;
                    end
                    recov_nxt = recov_r - 16'h0001;
                end
            end
            default: sup_nxt = SUP_IDLE;
        endcase
        modes_nxt.supplement        = (sup_nxt != SUP_IDLE);
        modes_nxt.sys_output_enable = (sup_nxt != SUP_SHORT);
        // termination held off in either mode
        modes_nxt.termination_enable = ~sense_i.sys_at_power_path
                                     & (sup_nxt == SUP_IDLE);
        modes_nxt.thermal_reduce = sense_i.die_above_reg;
        // input switch opens, battery stays closed
        if (sense_i.die_above_shutdown) begin
            modes_nxt.input_switch_on = 1'b0;
        end else if (sense_i.die_cooled) begin
            modes_nxt.input_switch_on = 1'b1;
        end
        modes_nxt.battery_switch_on = 1'b1;
        status_nxt = 8'h00;
        status_nxt[ST_PATH_BIT]  = modes_nxt.auto_power_path_mode;
        status_nxt[ST_SUPPL_BIT] = modes_nxt.supplement;
        status_nxt[ST_SHORT_BIT] = (sup_nxt == SUP_SHORT);
        status_nxt[ST_THERM_BIT] = modes_nxt.thermal_reduce;
        status_nxt[ST_SHUT_BIT]  = ~modes_nxt.input_switch_on;
        status_nxt[ST_DROOP_BIT] = modes_nxt.reduce_input_limit;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            sup_r    <= SUP_IDLE;
            us_cnt_r <= 7'h00;
            recov_r  <= 16'h0000;
            modes_r  <= '{input_switch_on: 1'b1, battery_switch_on: 1'b1,
                          sys_output_enable: 1'b1,
                          termination_enable: 1'b1, default: 1'b0};
            status_r <= 8'h00;
        end else begin
            sup_r    <= sup_nxt;
            us_cnt_r <= us_cnt_nxt;
            recov_r  <= recov_nxt;
            modes_r  <= modes_nxt;
            status_r <= status_nxt;
        end
    end

    assign modes_o  = modes_r;
    assign status_o = status_r;
    assign sda_oe_o = oe_r;
    // open drain: only ever pulls low
    assign sda_o    = 1'b0;

    //--------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------
    a_addr_reject: assert property (@(posedge clock_i) disable iff (rst_i)
        (st_r == SL_ADDR && scl_fall && cnt_r == 4'h8 && !bus_start
         && power_on_done_i && sh_r[7:1] != DEV_ADDR)
        |=> st_r == SL_IDLE ##1 !oe_r)
        else $error("foreign address answered");
    a_por_hold: assert property (@(posedge clock_i) disable iff (rst_i)
        !power_on_done_i[*2] |-> !oe_r && st_r == SL_IDLE)
        else $error("bus active before power-on done");
    a_status_wr_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
        (st_r == SL_WR && ptr_r == CHARGER_STATUS_REG_ADDR) |-> !mem_we)
        else $error("status register written");
    a_ptr_step: assert property (@(posedge clock_i) disable iff (rst_i)
        (st_r == SL_WR_ACK && $rose(oe_r)) |-> ptr_r == $past(ptr_r) + 8'h01)
        else $error("pointer did not advance");
    a_droop_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
        (sense_i.input_limit_sel != INPUT_LIMIT_LOW
         && sense_i.input_limit_sel != INPUT_LIMIT_HIGH)
        |=> !modes_r.input_droop_guard && !modes_r.reduce_input_limit)
        else $error("droop guard active on other limit");
    a_droop_reduce: assert property (@(posedge clock_i) disable iff (rst_i)
        (sense_i.input_limit_sel == INPUT_LIMIT_HIGH && sense_i.vin_below_droop
         && sense_i.charger_type_code == CHARGER_TYPE_SDP)
        |=> modes_r.reduce_input_limit)
        else $error("droop did not reduce limit");
    a_sw_enable: assert property (@(posedge clock_i) disable iff (rst_i)
        (sense_i.input_limit_sel == INPUT_LIMIT_LOW
         && sense_i.charger_type_code != CHARGER_TYPE_SDP)
        |=> modes_r.input_droop_guard == $past(ctrl0_r[DROOP_GUARD_ENABLE_BIT]))
        else $error("droop guard ignores software bit");
    a_term_block: assert property (@(posedge clock_i) disable iff (rst_i)
        (modes_r.auto_power_path_mode || modes_r.supplement)
        |-> !modes_r.termination_enable)
        else $error("termination allowed in power path");
    a_short_wait: assert property (@(posedge clock_i) disable iff (rst_i)
        (sup_r == SUP_ACTIVE && sense_i.bat_sys_short)
        |=> !modes_r.sys_output_enable [*8])
        else $error("rail not held off after short");
    a_shutdown_sw: assert property (@(posedge clock_i) disable iff (rst_i)
        sense_i.die_above_shutdown
        |=> !modes_r.input_switch_on && modes_r.battery_switch_on
            && ctrl0_r[THERMAL_EVENT_BIT])
        else $error("shutdown switching wrong");
    a_thermal_reduce: assert property (@(posedge clock_i) disable iff (rst_i)
        sense_i.die_above_reg |=> modes_r.thermal_reduce)
        else $error("no thermal charge reduction");
endmodule // pcc_charger_ctrl

// ==== pcc_i2c_host.sv ====
module pcc_i2c_host
    import pcc_pkg::*;
#(
    parameter int Q = 80  // quarter bit: 320 cycles a bit, 390 kb/s
) (
    input  wire logic clock_i,   // system clock
    input  wire logic sda_i,     // wired sda level
    output logic      scl_o,     // bus clock, idle high
    output logic      sda_oe_o   // high pulls sda low
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clock_i);
    endtask

    task automatic bit_x(input logic b, output logic r);
        sda_oe_o = ~b;
        wt(Q);
        scl_o = 1'b1;
        wt(Q);
        r = sda_i;
        wt(Q);
        scl_o = 1'b0;
        wt(Q);
    endtask

    // also serves as repeated start from scl low
    task automatic start();
        sda_oe_o = 1'b0;
        wt(Q);
        scl_o = 1'b1;
        wt(Q);
        sda_oe_o = 1'b1;
        wt(Q);
        scl_o = 1'b0;
        wt(Q);
    endtask

    task automatic stop();
        sda_oe_o = 1'b1;
        wt(Q);
        scl_o = 1'b1;
        wt(Q);
        sda_oe_o = 1'b0;
        wt(Q);
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask

    // master acks every read byte but the last
    task automatic rd_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, r);
            d[i] = r;
        end
        bit_x(last, r);
    endtask

    task automatic write_frame(input logic [6:0] dev, input logic [7:0] ra,
                               input logic [7:0] d0, input logic [7:0] d1,
                               input int n, output logic [3:0] acks);
        acks = 4'h0;
        start();
        wr_byte({dev, 1'b0}, acks[0]);
        if (acks[0]) wr_byte(ra, acks[1]);
        if (acks[0] && n > 0) wr_byte(d0, acks[2]);
        if (acks[0] && n > 1) wr_byte(d1, acks[3]);
        stop();
    endtask

    task automatic read_frame(input logic [7:0] ra, input int n,
                              output logic [7:0] d0, output logic [7:0] d1);
        logic a;
        d1 = 8'h00;
        start();
        wr_byte({DEV_ADDR, 1'b0}, a);
        wr_byte(ra, a);
        start();
        wr_byte({DEV_ADDR, 1'b1}, a);
        rd_byte(n == 1, d0);
        if (n > 1) rd_byte(1'b1, d1);
        stop();
    endtask
endmodule // pcc_i2c_host

// ==== pcc_charger_ctrl_tb_top.sv ====
module pcc_charger_ctrl_tb_top
    import pcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RECOV = 2;  // short wait cut to keep the run brief
    logic          clk;
    logic          rst;
    logic          pod;
    logic          scl;
    logic          dut_sda;
    logic          dut_oe;
    logic          host_oe;
    wire logic     sda_w;
    pcc_sense_type sense;
    pcc_mode_type  modes;
    pcc_mode_type  e;
    logic [7:0]    status;
    logic [7:0]    r0;
    logic [7:0]    r1;
    logic [3:0]    acks;
    int            mismatches;
    int            comparisons;

    // pulled-up wire: low when either side pulls
    assign sda_w = (dut_oe ? dut_sda : 1'b1) & ~host_oe;

    pcc_charger_ctrl #(.SHORT_RECOV_US(RECOV)) dut (
        .clock_i(clk), .rst_i(rst), .power_on_done_i(pod), .scl_i(scl),
        .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_o(dut_oe), .sense_i(sense),
        .modes_o(modes), .status_o(status));

    pcc_i2c_host host (.clock_i(clk), .sda_i(sda_w), .scl_o(scl),
                       .sda_oe_o(host_oe));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk({15'h0, got}, {15'h0, exp});
    endtask

    task automatic settle();
        repeat (2) @(negedge clk);
    endtask

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // about 70k cycles expected; give up at 90k
    initial begin
        #720_000;
        mismatches++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        pod = 1'b0;
        sense = '0;
        sense.charger_type_code = 3'h1;
        e = '0;
        e.termination_enable = 1'b1;
        e.sys_output_enable = 1'b1;
        e.input_switch_on = 1'b1;
        e.battery_switch_on = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        settle();
        chk({6'h0, modes}, {6'h0, e});
        chk({8'h0, status}, 16'h0);
        host.write_frame(DEV_ADDR, 8'h01, 8'h33, 8'h00, 1, acks);
        chk({12'h0, acks}, 16'h0);
        pod = 1'b1;
        settle();
        for (int k = 0; k < 2; k++) begin
            host.write_frame(k ? 7'h52 : 7'h13, 8'h01, 8'h44, 8'h0, 1, acks);
            chk({12'h0, acks}, 16'h0);
        end
        host.write_frame(DEV_ADDR, CHARGER_STATUS_REG_ADDR, 8'h00, 8'h00,
                         1, acks);
        chk({12'h0, acks}, 16'h7);
        chk({8'h0, status}, 16'h0);
        host.write_frame(DEV_ADDR, 8'h01, 8'h5a, 8'ha5, 2, acks);
        chk({12'h0, acks}, 16'hf);
        host.read_frame(8'h01, 2, r0, r1);
        chk({8'h0, r0}, 16'h5a);
        chk({8'h0, r1}, 16'ha5);
        host.read_frame(CONTROL_REG_ZERO_ADDR, 1, r0, r1);
        chk({8'h0, r0 & ~CONTROL_REG_ZERO_RO},
            {8'h0, CONTROL_REG_ZERO_RST & ~CONTROL_REG_ZERO_RO});
        sense.vin_below_droop = 1'b1;
        settle();
        chk_flag(modes.reduce_input_limit, 1'b0);
        sense.charger_type_code = CHARGER_TYPE_SDP;
        sense.input_limit_sel = INPUT_LIMIT_HIGH;
        settle();
        chk_flag(modes.input_droop_guard, 1'b1);
        chk_flag(modes.reduce_input_limit, 1'b1);
        sense.input_limit_sel = 2'h2;
        settle();
        chk_flag(modes.reduce_input_limit, 1'b0);
        sense.input_limit_sel = INPUT_LIMIT_LOW;
        sense.charger_type_code = 3'h1;
        host.write_frame(DEV_ADDR, CONTROL_REG_ZERO_ADDR, 8'h99, 8'h0, 1, acks);
        settle();
        chk_flag(modes.input_droop_guard, 1'b1);
        chk_flag(modes.reduce_input_limit, 1'b1);
        sense.vin_below_droop = 1'b0;
        sense.sys_at_power_path = 1'b1;
        settle();
        chk_flag(modes.auto_power_path_mode, 1'b1);
        chk_flag(modes.charge_cut, 1'b1);
        chk({8'h0, status}, 16'h1 << ST_PATH_BIT);
        chk_flag(modes.termination_enable, 1'b0);
        sense.sys_at_power_path = 1'b0;
        settle();
        chk_flag(modes.termination_enable, 1'b1);
        sense.sys_below_bat = 1'b1;
        settle();
        chk_flag(modes.supplement, 1'b1);
        chk_flag(modes.termination_enable, 1'b0);
        sense.sys_below_bat = 1'b0;
        settle();
        chk_flag(modes.supplement, 1'b1);
        sense.bat_sys_short = 1'b1;
        @(negedge clk);
        sense.bat_sys_short = 1'b0;
        settle();
        chk_flag(modes.sys_output_enable, 1'b0);
        chk({8'h0, status},
            (16'h1 << ST_SUPPL_BIT) | (16'h1 << ST_SHORT_BIT));
        repeat (118) @(negedge clk);
        chk_flag(modes.sys_output_enable, 1'b0);
        repeat (140) @(negedge clk);
        chk_flag(modes.sys_output_enable, 1'b1);
        sense.bat_below_sys = 1'b1;
        settle();
        chk_flag(modes.supplement, 1'b0);
        sense.bat_below_sys = 1'b0;
        sense.die_above_reg = 1'b1;
        settle();
        chk_flag(modes.thermal_reduce, 1'b1);
        sense.die_above_shutdown = 1'b1;
        settle();
        chk_flag(modes.input_switch_on, 1'b0);
        chk_flag(modes.battery_switch_on, 1'b1);
        chk({8'h0, status},
            (16'h1 << ST_THERM_BIT) | (16'h1 << ST_SHUT_BIT));
        sense.die_above_shutdown = 1'b0;
        settle();
        chk_flag(modes.input_switch_on, 1'b0);
        sense.die_cooled = 1'b1;
        settle();
        chk_flag(modes.input_switch_on, 1'b1);
        conclude();
    end
endmodule // pcc_charger_ctrl_tb_top
